// >>> hw/pwr_seq.sv
// Functional notes
// - power-on reset enters sleep; relay open, no motherboard pulse.
// - long inactivity after power down drops from idle into sleep.
// - accessory high with good battery and temperature closes relay, LED solid.
// - start pulse issued start_delay (2 s) after relay closes.
// - running leaves to count down on accessory low or battery low.
// - count down waits countdown_delay from delay_trim, 0 to 30 minutes.
// - LED blinks once per second during count down.
// - user button low in count down zeroes delay, enters power down.
// - accessory high again in count down resumes running with no pulse.
// - battery low in count down shortens remaining time to a short interval.
// - count down expiry sends shutdown pulse if computer on, and enters power down.
// - power down waits up to shutdown_wait 90 s, ends when computer off.
// - LED blinks twice per second during power down.
// - accessory high in power down restarts running after computer shuts down.
// - battery low only after staying below trip for five seconds.
// - battery good again only above trip plus 450 mV margin.
// - trip level chosen by trip_level_trim over ten to twelve volts.
// - engine running sensed when battery reaches about thirteen volts.
// - computer-on sense high means powered, low means off.
// - board and auxiliary switch outputs are active low open collector.
// - voltage-sense start mode waits for engine running level before start from sleep or idle.
// - temperature out of range blocks power up, forces immediate power down.
`timescale 1ns/1ps
`default_nettype none

module pwr_seq #(
  parameter int TICK_CYCLES = pwr_seq_pkg::TICK_CYCLES,
  parameter int MS_PER_S = pwr_seq_pkg::MS_PER_S,
  parameter int START_DELAY_MS = pwr_seq_pkg::START_DELAY_MS,
  parameter int SHUTDOWN_WAIT_MS = pwr_seq_pkg::SHUTDOWN_WAIT_MS,
  parameter int LOWV_FILTER_MS = pwr_seq_pkg::LOWV_FILTER_MS,
  parameter int IDLE_TO_SLEEP_MS = pwr_seq_pkg::IDLE_TO_SLEEP_MS,
  parameter int PULSE_MS = pwr_seq_pkg::PULSE_MS
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_B,
  // vehicle and computer sense
  input wire logic IGNITION_ACCESSORY_IN,
  input wire logic BATT_ABOVE_TRIP,
  input wire logic BATT_ABOVE_HYST,
  input wire logic BATT_ENGINE_RUN,
  input wire logic TEMP_IN_RANGE,
  input wire logic USER_BUTTON_IN_N,
  input wire logic COMPUTER_ON_IN,
  // power outputs
  output logic SWITCHED_LOAD_OUT,
  output logic BOARD_SWITCH_OUT,
  output logic BOARD_SWITCH_OE_N,
  output logic AUXILIARY_SWITCH_OUT,
  output logic AUXILIARY_SWITCH_OE_N,
  output logic INDICATOR_LED,
  output logic [pwr_seq_pkg::TRIP_W-1:0] TRIP_LEVEL_TRIM,
  // avalon-mm slave
  input wire logic [pwr_seq_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic blink(input logic [31:0] ms, input int period);
    return (ms % 32'(period)) < 32'(period / 2);
  endfunction

  pwr_seq_pkg::state_t state_ff;
  logic [31:0] tick_cnt_ff;
  logic ms_tick_ff;
  logic [31:0] ms_in_sec_ff;
  logic sec_tick;
  logic [31:0] tmr_ff;
  logic [pwr_seq_pkg::CD_W-1:0] cd_ff;
  logic restart_ff;
  logic batt_good_ff;
  logic [31:0] lv_ff;
  logic vstart_ff;
  logic [pwr_seq_pkg::CD_W-1:0] delay_trim_ff;
  logic [pwr_seq_pkg::TRIP_W-1:0] trip_trim_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic relay_ff;
  logic board_oe_n_ff;
  logic led_ff;
  logic start_ok;
  logic [pwr_seq_pkg::CD_W-1:0] lowbat_cd;
  logic [31:0] wr_word;

  assign sec_tick = ms_tick_ff && (ms_in_sec_ff == 32'(MS_PER_S - 1));
  assign lowbat_cd = pwr_seq_pkg::CD_W'(pwr_seq_pkg::LOWBAT_CD_S);
  // level start lets a late battery recovery or engine start still wake it
  assign start_ok = IGNITION_ACCESSORY_IN && batt_good_ff && TEMP_IN_RANGE &&
                    (!vstart_ff || BATT_ENGINE_RUN);

  // ------------------------------------------------------------
  // time base
  // ------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      tick_cnt_ff <= 32'h0000_0000;
      ms_tick_ff <= 1'b0;
    end else if (tick_cnt_ff == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_ff <= 32'h0000_0000;
      ms_tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
      ms_tick_ff <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      ms_in_sec_ff <= 32'h0000_0000;
    end else if (sec_tick) begin
      ms_in_sec_ff <= 32'h0000_0000;
    end else if (ms_tick_ff) begin
      ms_in_sec_ff <= ms_in_sec_ff + 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------
  // battery filter
  // ------------------------------------------------------------
  // trip and margin compares are made outside against trip_level_trim
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      batt_good_ff <= 1'b0;
      lv_ff <= 32'h0000_0000;
    end else if (batt_good_ff) begin
      if (BATT_ABOVE_TRIP) begin
        lv_ff <= 32'h0000_0000;
      end else if (ms_tick_ff) begin
        if (lv_ff == 32'(LOWV_FILTER_MS - 1)) begin
          batt_good_ff <= 1'b0;
          lv_ff <= 32'h0000_0000;
        end else begin
          lv_ff <= lv_ff + 32'h0000_0001;
        end
      end
    end else if (BATT_ABOVE_HYST) begin
      batt_good_ff <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // mode sequencer
  // ------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      state_ff <= pwr_seq_pkg::S_SLEEP;
      tmr_ff <= 32'h0000_0000;
      cd_ff <= '0;
      restart_ff <= 1'b0;
    end else begin
      case (state_ff)
        pwr_seq_pkg::S_SLEEP, pwr_seq_pkg::S_IDLE: begin
          restart_ff <= 1'b0;
          if (start_ok) begin
            state_ff <= pwr_seq_pkg::S_RUN_WAIT;
            tmr_ff <= 32'h0000_0000;
          end else if (state_ff == pwr_seq_pkg::S_IDLE && ms_tick_ff) begin
            if (tmr_ff == 32'(IDLE_TO_SLEEP_MS - 1)) begin
              state_ff <= pwr_seq_pkg::S_SLEEP;
            end else begin
              tmr_ff <= tmr_ff + 32'h0000_0001;
            end
          end
        end
        pwr_seq_pkg::S_RUN_WAIT: begin
          if (!TEMP_IN_RANGE) begin
            state_ff <= pwr_seq_pkg::S_IDLE;
            tmr_ff <= 32'h0000_0000;
          end else if (ms_tick_ff) begin
            if (tmr_ff == 32'(START_DELAY_MS - 1)) begin
              state_ff <= pwr_seq_pkg::S_RUN_PULSE;
              tmr_ff <= 32'h0000_0000;
            end else begin
              tmr_ff <= tmr_ff + 32'h0000_0001;
            end
          end
        end
        pwr_seq_pkg::S_RUN_PULSE: begin
          if (ms_tick_ff) begin
            if (tmr_ff == 32'(PULSE_MS - 1)) begin
              state_ff <= pwr_seq_pkg::S_RUNNING;
              tmr_ff <= 32'h0000_0000;
            end else begin
              tmr_ff <= tmr_ff + 32'h0000_0001;
            end
          end
        end
        pwr_seq_pkg::S_RUNNING: begin
          if (!TEMP_IN_RANGE) begin
            state_ff <= COMPUTER_ON_IN ? pwr_seq_pkg::S_PD_PULSE
                                       : pwr_seq_pkg::S_PD_WAIT;
            tmr_ff <= 32'h0000_0000;
          end else if (!IGNITION_ACCESSORY_IN || !batt_good_ff) begin
            state_ff <= pwr_seq_pkg::S_COUNTDOWN;
            if (!batt_good_ff && delay_trim_ff > lowbat_cd) begin
              cd_ff <= lowbat_cd;
            end else begin
              cd_ff <= delay_trim_ff;
            end
          end
        end
        pwr_seq_pkg::S_COUNTDOWN: begin
          tmr_ff <= 32'h0000_0000;
          if (!TEMP_IN_RANGE || !USER_BUTTON_IN_N || cd_ff == '0) begin
            state_ff <= COMPUTER_ON_IN ? pwr_seq_pkg::S_PD_PULSE
                                       : pwr_seq_pkg::S_PD_WAIT;
            cd_ff <= '0;
          end else if (IGNITION_ACCESSORY_IN && batt_good_ff) begin
            state_ff <= pwr_seq_pkg::S_RUNNING;
          end else if (!batt_good_ff && cd_ff > lowbat_cd) begin
            cd_ff <= lowbat_cd;
          end else if (sec_tick) begin
            cd_ff <= cd_ff - pwr_seq_pkg::CD_W'(1);
          end
        end
        pwr_seq_pkg::S_PD_PULSE: begin
          if (IGNITION_ACCESSORY_IN) begin
            restart_ff <= 1'b1;
          end
          if (ms_tick_ff) begin
            if (tmr_ff == 32'(PULSE_MS - 1)) begin
              state_ff <= pwr_seq_pkg::S_PD_WAIT;
              tmr_ff <= 32'h0000_0000;
            end else begin
              tmr_ff <= tmr_ff + 32'h0000_0001;
            end
          end
        end
        pwr_seq_pkg::S_PD_WAIT: begin
          // a low sense level means the supply rail is gone
          if (!COMPUTER_ON_IN || (ms_tick_ff && tmr_ff == 32'(SHUTDOWN_WAIT_MS - 1))) begin
            tmr_ff <= 32'h0000_0000;
            if ((restart_ff || IGNITION_ACCESSORY_IN) && batt_good_ff && TEMP_IN_RANGE) begin
              state_ff <= pwr_seq_pkg::S_RUN_WAIT;
            end else begin
              state_ff <= pwr_seq_pkg::S_IDLE;
            end
            restart_ff <= 1'b0;
          end else begin
            if (IGNITION_ACCESSORY_IN) begin
              restart_ff <= 1'b1;
            end
            if (ms_tick_ff) begin
              tmr_ff <= tmr_ff + 32'h0000_0001;
            end
          end
        end
        default: begin
          state_ff <= pwr_seq_pkg::S_SLEEP;
          tmr_ff <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      relay_ff <= 1'b0;
      board_oe_n_ff <= 1'b1;
      led_ff <= 1'b0;
    end else begin
      relay_ff <= !(state_ff == pwr_seq_pkg::S_SLEEP ||
                    state_ff == pwr_seq_pkg::S_IDLE);
      // open collector: enable low pulls the header pin to ground
      board_oe_n_ff <= !(state_ff == pwr_seq_pkg::S_RUN_PULSE ||
                         state_ff == pwr_seq_pkg::S_PD_PULSE);
      case (state_ff)
        pwr_seq_pkg::S_RUN_WAIT, pwr_seq_pkg::S_RUN_PULSE, pwr_seq_pkg::S_RUNNING: begin
          led_ff <= 1'b1;
        end
        pwr_seq_pkg::S_COUNTDOWN: begin
          // blink periods follow the second counter so a shortened time base scales too
          led_ff <= blink(ms_in_sec_ff, MS_PER_S);
        end
        pwr_seq_pkg::S_PD_PULSE, pwr_seq_pkg::S_PD_WAIT: begin
          led_ff <= blink(ms_in_sec_ff, MS_PER_S / 2);
        end
        default: begin
          led_ff <= 1'b0;
        end
      endcase
    end
  end

  assign SWITCHED_LOAD_OUT = relay_ff;
  assign BOARD_SWITCH_OE_N = board_oe_n_ff;
  assign BOARD_SWITCH_OUT = 1'b0;
  // auxiliary supply follows the relay
  assign AUXILIARY_SWITCH_OE_N = !relay_ff;
  assign AUXILIARY_SWITCH_OUT = 1'b0;
  assign INDICATOR_LED = led_ff;
  assign TRIP_LEVEL_TRIM = trip_trim_ff;

  // ------------------------------------------------------------
  // register slave
  // ------------------------------------------------------------
  // one wait cycle per access keeps read data registered
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wait_ff <= !((AVS_READ || AVS_WRITE) && wait_ff);
      if (AVS_READ && wait_ff) begin
        case (AVS_ADDRESS)
          pwr_seq_pkg::OFS_CTRL: rdata_ff <= 32'(vstart_ff);
          pwr_seq_pkg::OFS_DELAY: rdata_ff <= 32'(delay_trim_ff);
          pwr_seq_pkg::OFS_TRIP: rdata_ff <= 32'(trip_trim_ff);
          pwr_seq_pkg::OFS_STATUS: begin
            rdata_ff <= (32'(state_ff) << pwr_seq_pkg::ST_STATE_LSB) |
                        (32'(batt_good_ff) << pwr_seq_pkg::ST_GOOD_BIT) |
                        (32'(relay_ff) << pwr_seq_pkg::ST_RELAY_BIT) |
                        (32'(cd_ff) << pwr_seq_pkg::ST_REMAIN_LSB);
          end
          default: rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign AVS_WAITREQUEST = wait_ff;
  assign AVS_READDATA = rdata_ff;

  always_comb begin
    wr_word = 32'h0000_0000;
    case (AVS_ADDRESS)
      pwr_seq_pkg::OFS_CTRL: wr_word = be_merge(32'(vstart_ff), AVS_WRITEDATA, AVS_BYTEENABLE);
      pwr_seq_pkg::OFS_DELAY: wr_word = be_merge(32'(delay_trim_ff), AVS_WRITEDATA,
                                                 AVS_BYTEENABLE);
      pwr_seq_pkg::OFS_TRIP: wr_word = be_merge(32'(trip_trim_ff), AVS_WRITEDATA,
                                                AVS_BYTEENABLE);
      default: wr_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      vstart_ff <= pwr_seq_pkg::CTRL_RST;
      delay_trim_ff <= pwr_seq_pkg::DELAY_RST;
      trip_trim_ff <= pwr_seq_pkg::TRIP_RST;
    end else if (AVS_WRITE && !wait_ff) begin
      case (AVS_ADDRESS)
        pwr_seq_pkg::OFS_CTRL: vstart_ff <= wr_word[pwr_seq_pkg::CTRL_VSTART_BIT];
        pwr_seq_pkg::OFS_DELAY: begin
          // longer settings saturate at the thirty minute ceiling
          if (wr_word > 32'(pwr_seq_pkg::CD_MAX_S)) begin
            delay_trim_ff <= pwr_seq_pkg::CD_W'(pwr_seq_pkg::CD_MAX_S);
          end else begin
            delay_trim_ff <= wr_word[pwr_seq_pkg::CD_W-1:0];
          end
        end
        pwr_seq_pkg::OFS_TRIP: trip_trim_ff <= wr_word[pwr_seq_pkg::TRIP_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_cd_user;
    state_ff == pwr_seq_pkg::S_COUNTDOWN && !USER_BUTTON_IN_N;
  endsequence

  sequence s_cd_resume;
    state_ff == pwr_seq_pkg::S_COUNTDOWN && USER_BUTTON_IN_N && TEMP_IN_RANGE &&
      cd_ff != '0 && IGNITION_ACCESSORY_IN && batt_good_ff;
  endsequence

  a_reset_sleep: assert property (@(posedge MCLK) $past(!RST_B) && RST_B |->
    state_ff == pwr_seq_pkg::S_SLEEP && !SWITCHED_LOAD_OUT && BOARD_SWITCH_OE_N)
    else $error("reset did not leave sleep with outputs idle");

  a_start_cond: assert property (@(posedge MCLK) disable iff (!RST_B)
    state_ff == pwr_seq_pkg::S_RUN_WAIT && $past(state_ff) != pwr_seq_pkg::S_RUN_WAIT &&
    $past(state_ff) != pwr_seq_pkg::S_PD_WAIT |->
    $past(IGNITION_ACCESSORY_IN && batt_good_ff && TEMP_IN_RANGE))
    else $error("start without accessory, battery or temperature");

  a_vstart_engine: assert property (@(posedge MCLK) disable iff (!RST_B)
    state_ff == pwr_seq_pkg::S_RUN_WAIT && $past(state_ff) == pwr_seq_pkg::S_SLEEP &&
    $past(vstart_ff) |-> $past(BATT_ENGINE_RUN))
    else $error("voltage start mode started below engine level");

  a_start_delay: assert property (@(posedge MCLK) disable iff (!RST_B)
    state_ff == pwr_seq_pkg::S_RUN_PULSE && $past(state_ff) == pwr_seq_pkg::S_RUN_WAIT |->
    $past(tmr_ff) == 32'(START_DELAY_MS - 1) && $past(ms_tick_ff))
    else $error("start pulse not at the start delay");

  a_user_abort: assert property (@(posedge MCLK) disable iff (!RST_B)
    s_cd_user |=> state_ff == pwr_seq_pkg::S_PD_PULSE ||
    state_ff == pwr_seq_pkg::S_PD_WAIT)
    else $error("user button did not end count down");

  a_cd_resume: assert property (@(posedge MCLK) disable iff (!RST_B)
    s_cd_resume |=> state_ff == pwr_seq_pkg::S_RUNNING ##1 BOARD_SWITCH_OE_N)
    else $error("count down did not resume running without pulse");

  a_pd_comp_off: assert property (@(posedge MCLK) disable iff (!RST_B)
    state_ff == pwr_seq_pkg::S_PD_WAIT && !COMPUTER_ON_IN |=>
    state_ff != pwr_seq_pkg::S_PD_WAIT)
    else $error("power down wait ignored computer off");

  a_lowv_filter: assert property (@(posedge MCLK) disable iff (!RST_B)
    $fell(batt_good_ff) |-> $past(lv_ff) == 32'(LOWV_FILTER_MS - 1) &&
    $past(!BATT_ABOVE_TRIP))
    else $error("battery declared low before filter time");

  a_hyst_good: assert property (@(posedge MCLK) disable iff (!RST_B)
    $rose(batt_good_ff) |-> $past(BATT_ABOVE_HYST))
    else $error("battery good without hysteresis margin");

  a_pulse_only: assert property (@(posedge MCLK) disable iff (!RST_B)
    !BOARD_SWITCH_OE_N |-> $past(state_ff) == pwr_seq_pkg::S_RUN_PULSE ||
    $past(state_ff) == pwr_seq_pkg::S_PD_PULSE)
    else $error("board switch driven outside a pulse");

  a_relay_open: assert property (@(posedge MCLK) disable iff (!RST_B)
    state_ff == pwr_seq_pkg::S_PD_WAIT ##1 state_ff == pwr_seq_pkg::S_IDLE |=>
    !SWITCHED_LOAD_OUT && AUXILIARY_SWITCH_OE_N)
    else $error("relay left closed after power down");

endmodule

`default_nettype wire

// >>> hw/pwr_seq_pkg.sv
package pwr_seq_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;
  localparam int START_DELAY_S = 2;
  localparam int START_DELAY_MS = START_DELAY_S * MS_PER_S;
  localparam int SHUTDOWN_WAIT_S = 90;
  localparam int SHUTDOWN_WAIT_MS = SHUTDOWN_WAIT_S * MS_PER_S;
  localparam int LOWV_FILTER_S = 5;
  localparam int LOWV_FILTER_MS = LOWV_FILTER_S * MS_PER_S;
  localparam int PULSE_MS = 300;
  localparam int IDLE_TO_SLEEP_S = 60;
  localparam int IDLE_TO_SLEEP_MS = IDLE_TO_SLEEP_S * MS_PER_S;
  localparam int LOWBAT_CD_S = 2;
  localparam int CD_MAX_MIN = 30;
  localparam int CD_MAX_S = CD_MAX_MIN * 60;
  localparam int BLINK1_PERIOD_MS = 1000;
  localparam int BLINK2_PERIOD_MS = 500;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int CD_W = 11;
  localparam int TRIP_W = 8;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_DELAY = 4'h4;
  localparam logic [3:0] OFS_TRIP = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  localparam int CTRL_VSTART_BIT = 0;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_GOOD_BIT = 4;
  localparam int ST_RELAY_BIT = 5;
  localparam int ST_REMAIN_LSB = 16;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [10:0] DELAY_RST = 11'h384;
  localparam logic [7:0] TRIP_RST = 8'h80;

  // ------------------------------------------------------------
  // modes
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    S_SLEEP = 4'h0,
    S_IDLE = 4'h1,
    S_RUN_WAIT = 4'h2,
    S_RUN_PULSE = 4'h3,
    S_RUNNING = 4'h4,
    S_COUNTDOWN = 4'h5,
    S_PD_PULSE = 4'h6,
    S_PD_WAIT = 4'h7
  } state_t;

endpackage

// >>> tb/pc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// motherboard behind the switch header
// ----------------------------------------
module pc_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // switch header and sense
  input wire logic oe_n,
  output logic pc_on,
  output int pulses
);
  logic prev_ff;
  // power flips on release, like a front-panel button; sense high = on
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prev_ff <= 1'b1;
      pc_on <= 1'b0;
      pulses <= 0;
    end else begin
      prev_ff <= oe_n;
      if (prev_ff === 1'b0 && oe_n === 1'b1) begin
        pulses <= pulses + 1;
        pc_on <= !pc_on;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ----------------------------------------
  // harness
  // ----------------------------------------
  typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic clk, rst_b, acc, hyst, temp, btn_n, rd, wr, load, oe_n, aux_n, led, wreq, bso, pc_on;
  logic trip, eng, aso, pl;
  logic [3:0] addr, be;
  int flips;
  logic [7:0] trim;
  logic [31:0] wd, rdata, q;
  int pulses, p0, n, miscompares, samples_checked;
  // last row leaves a 3 s count down so the button clearly cuts it short
  row_t rows[5] = '{'{pwr_seq_pkg::OFS_DELAY, 32'h0000_07d0, 32'h0000_0708},
    '{pwr_seq_pkg::OFS_TRIP, 32'h0000_0033, 32'h0000_0033},
    '{pwr_seq_pkg::OFS_CTRL, 32'h0000_0000, 32'h0000_0000},
    '{4'h2, 32'h0000_ffff, 32'h0000_0000},
    '{pwr_seq_pkg::OFS_DELAY, 32'h0000_0003, 32'h0000_0003}};
  pwr_seq #(.TICK_CYCLES(4), .MS_PER_S(10), .START_DELAY_MS(5), .SHUTDOWN_WAIT_MS(20),
    .LOWV_FILTER_MS(5), .IDLE_TO_SLEEP_MS(20), .PULSE_MS(3)) pwr_seq_i (
    .MCLK(clk), .RST_B(rst_b), .IGNITION_ACCESSORY_IN(acc), .BATT_ABOVE_TRIP(trip),
    .BATT_ABOVE_HYST(hyst), .BATT_ENGINE_RUN(eng), .TEMP_IN_RANGE(temp),
    .USER_BUTTON_IN_N(btn_n), .COMPUTER_ON_IN(pc_on), .SWITCHED_LOAD_OUT(load),
    .BOARD_SWITCH_OUT(bso), .BOARD_SWITCH_OE_N(oe_n), .AUXILIARY_SWITCH_OUT(aso),
    .AUXILIARY_SWITCH_OE_N(aux_n), .INDICATOR_LED(led), .TRIP_LEVEL_TRIM(trim),
    .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq));
  pc_model pc_model_i (.clk(clk), .rst_b(rst_b), .oe_n(oe_n), .pc_on(pc_on), .pulses(pulses));
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // request held until waitrequest is sampled low; data taken at that edge
  task bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    @(posedge clk iff wreq === 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task wst(input logic [3:0] s);
    int k;
    k = 0;
    do begin
      bus(pwr_seq_pkg::OFS_STATUS, 1'b0, 32'h0000_0000);
      k++;
    end while (q[3:0] !== s && k < 400);
    chk("state", 32'(s), 32'(q[3:0]));
  endtask
  task till(input logic v, input bit on_load, input int lim);
    n = 0;
    while (((on_load ? load : oe_n) !== v) && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #400000;
    miscompares++;
    close_out;
  end
  initial begin
    rst_b = 1'b0;
    acc = 1'b0;
    hyst = 1'b1;
    trip = 1'b1;
    eng = 1'b0;
    be = 4'hf;
    temp = 1'b0;
    btn_n = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 4'h0;
    wd = 32'h0000_0000;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    wst(pwr_seq_pkg::S_SLEEP);
    chk("relay", 32'h0000_0000, 32'(load));
    chk("board oe_n", 32'h0000_0001, 32'(oe_n));
    chk("board out", 32'h0000_0000, 32'(bso));
    chk("trim", 32'h0000_0080, 32'(trim));
    bus(pwr_seq_pkg::OFS_DELAY, 1'b0, 32'h0000_0000);
    chk("delay", 32'h0000_0384, q);
    foreach (rows[i]) begin
      bus(rows[i].a, 1'b1, rows[i].d);
      bus(rows[i].a, 1'b0, 32'h0000_0000);
      chk("register", rows[i].e, q);
    end
    chk("trim", 32'h0000_0033, 32'(trim));
    be <= 4'h0;
    bus(pwr_seq_pkg::OFS_TRIP, 1'b1, 32'h0000_00ff);
    be <= 4'hf;
    bus(pwr_seq_pkg::OFS_TRIP, 1'b0, 32'h0000_0000);
    chk("masked write", 32'h0000_0033, q);
    acc <= 1'b1;
    till(1'b1, 1'b1, 60);
    chk("hot start", 32'h0000_0000, 32'(load));
    temp <= 1'b1;
    till(1'b1, 1'b1, 60);
    chk("led", 32'h0000_0001, 32'(led));
    chk("aux oe_n", 32'h0000_0000, 32'(aux_n));
    till(1'b0, 1'b0, 100);
    chk("start delay", 32'h0000_0001, 32'(n >= 14 && n <= 24));
    till(1'b1, 1'b0, 100);
    chk("pulse width", 32'h0000_0001, 32'(n >= 8 && n <= 16));
    wst(pwr_seq_pkg::S_RUNNING);
    p0 = pulses;
    acc <= 1'b0;
    wst(pwr_seq_pkg::S_COUNTDOWN);
    acc <= 1'b1;
    wst(pwr_seq_pkg::S_RUNNING);
    chk("resume pulses", p0, pulses);
    acc <= 1'b0;
    wst(pwr_seq_pkg::S_COUNTDOWN);
    flips = 0;
    pl = led;
    repeat (60) begin
      @(posedge clk);
      if (led !== pl) flips++;
      pl = led;
    end
    chk("blink", 32'h0000_0001, 32'(flips >= 2));
    btn_n <= 1'b0;
    wst(pwr_seq_pkg::S_IDLE);
    chk("off pulses", p0 + 1, pulses);
    repeat (3) @(posedge clk);
    chk("relay open", 32'h0000_0000, 32'(load));
    btn_n <= 1'b1;
    acc <= 1'b1;
    wst(pwr_seq_pkg::S_RUNNING);
    hyst <= 1'b0;
    trip <= 1'b0;
    repeat (8) @(posedge clk);
    bus(pwr_seq_pkg::OFS_STATUS, 1'b0, 32'h0000_0000);
    chk("filtered", 32'(pwr_seq_pkg::S_RUNNING), 32'(q[3:0]));
    wst(pwr_seq_pkg::S_COUNTDOWN);
    wst(pwr_seq_pkg::S_IDLE);
    chk("low pulses", p0 + 3, pulses);
    wst(pwr_seq_pkg::S_SLEEP);
    chk("relay sleep", 32'h0000_0000, 32'(load));
    trip <= 1'b1;
    bus(pwr_seq_pkg::OFS_CTRL, 1'b1, 32'h0000_0001);
    repeat (60) @(posedge clk);
    chk("no hyst start", 32'h0000_0000, 32'(load));
    hyst <= 1'b1;
    repeat (60) @(posedge clk);
    chk("vstart wait", 32'h0000_0000, 32'(load));
    eng <= 1'b1;
    till(1'b1, 1'b1, 60);
    chk("vstart go", 32'h0000_0001, 32'(load));
    chk("aux out", 32'h0000_0000, 32'(aso));
    close_out;
  end
endmodule
`default_nettype wire
